// ### fault_history_log_tb_top.sv
// Purpose: Random and corner tests of the fault logger
// Assumes: Seed fixed, so runs repeat
// Notes:   Date and time share random bits with the diagnostics
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("ERROR %0t bad", $time); end end
module fault_history_log_tb_top;
	logic         clk, rst, fault_valid, fault_has_sub, fault_reset, clr_wr, clr_from_serial;
	logic         rd_en, rd_valid, pwr_enable, fault_active;
	logic [7:0]   fault_code, fault_action, rd_code, clr_data, c;
	logic [15:0]  fault_sub, cur_date, cur_time, rd_sub, rd_date, rd_time;
	logic [319:0] diag_live, diag_out;
	logic [3:0]   rd_idx;
	logic [55:0]  exp_q [10];
	int           errors, n_tests;
	fhl_top fhl_top_i(.*);
	fhl_master fhl_master_i(.*);
	function automatic [55:0] ent(input [7:0] k, input h, input [15:0] s);
		return {k, h ? s : 16'h0, cur_date, cur_time};
	endfunction
	task flt(input [7:0] k, input h, input [15:0] s);
		@(posedge clk);
		{fault_valid, fault_code, fault_has_sub, fault_sub} <= {1'h1, k, h, s};
		@(posedge clk);
		for (int j = 9; j > 0; j--) exp_q[j] = exp_q[j-1];
		exp_q[0] = ent(k, h, s);
		fault_valid <= 1'h0;
	endtask
	task chk(input [3:0] i);
		fhl_master_i.rd(i, c);
		`CHK({c, rd_sub, rd_date, rd_time}, i < 10 ? exp_q[i] : 56'h0)
		`CHK(rd_valid, 1'h1)
	endtask
	task stop_test;
		if (errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) {diag_live, cur_date, cur_time} <= {11{$urandom}};
	initial begin
		#100000;
		errors++;
		stop_test;
	end
	initial begin
		rst = 1'h1;
		{fault_valid, fault_has_sub, fault_reset, fault_code, fault_sub, fault_action} = 35'h0;
		{diag_live, cur_date, cur_time} = 352'h0;
		void'($urandom(32'hBE5F));
		exp_q = '{default: 56'h0};
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		@(negedge clk) `CHK(pwr_enable, 1'h1)
		flt(8'hFF, 1'h0, 16'hFFFF);
		repeat (11) flt($urandom, $urandom, $urandom);
		@(negedge clk) `CHK(pwr_enable, 1'h0)
		for (int i = 0; i < 16; i++) chk(i);
		fhl_master_i.clr(1'h0, 8'hFF);
		fhl_master_i.clr(1'h1, 8'hFE);
		chk(0);
		fhl_master_i.clr(1'h1, 8'hFF);
		exp_q = '{default: 56'h0};
		chk(0);
		chk(9);
		@(posedge clk) fault_reset <= 1'h1;
		@(posedge clk) fault_reset <= 1'h0;
		@(negedge clk) `CHK(fault_active, 1'h0)
		@(posedge clk) fault_action <= 8'h10;
		flt(8'h05, 1'h1, 16'h1234);
		chk(0);
		@(posedge clk) rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		exp_q = '{default: 56'h0};
		@(posedge clk);
		@(negedge clk) `CHK({pwr_enable, fault_active}, 2'h2)
		chk(0);
		chk(9);
		stop_test;
	end
endmodule
bind fhl_top fhl_props fhl_props_i(.*);

// ### fhl_defines.vh
// Purpose: Shared constants for the fault history logger
// Assumes: Included by bare name from design files
// Notes:   Log depth and field widths default through module parameters; index and action widths are fixed
`ifndef FHL_DEFINES_VH
`define FHL_DEFINES_VH
`define FHL_LOG_DEPTH     10
`define FHL_CODE_W        8
`define FHL_SUB_W         16
`define FHL_DATE_W        16
`define FHL_TIME_W        16
`define FHL_DIAG_N        20
`define FHL_DIAG_W        16
`define FHL_IDX_W         4
`define FHL_CLEAR_KEY     8'hFF
`define FHL_NOFRZ_BIT     4
`define FHL_ACT_W         8
`define FHL_ST_RUN        1'b0
`define FHL_ST_TRIP       1'b1
`endif

// ### fhl_master.sv
// Purpose: Serial master model that reads and clears the log
// Assumes: Tasks start at a rising edge
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
module fhl_master(
	input  wire       clk,
	input  wire [7:0] rd_code,
	output reg        rd_en,
	output reg  [3:0] rd_idx,
	output reg        clr_wr,
	output reg        clr_from_serial,
	output reg  [7:0] clr_data
);
	initial {rd_en, rd_idx, clr_wr, clr_from_serial, clr_data} = 15'h0;
	task rd(input [3:0] i, output [7:0] c);
		@(posedge clk);
		rd_en <= 1'h1;
		rd_idx <= i;
		@(posedge clk);
		rd_en <= 1'h0;
		rd_idx <= ~i;
		@(negedge clk);
		c = rd_code;
	endtask
	task clr(input s, input [7:0] v);
		@(posedge clk);
		clr_wr <= 1'h1;
		clr_from_serial <= s;
		clr_data <= v;
		@(posedge clk);
		clr_wr <= 1'h0;
		clr_data <= ~v;
	endtask
endmodule

// ### fhl_props.sv
// Purpose: Port checks for fhl_top
// Assumes: Freeze-disable bit only changes while not tripped
// Notes:   Bound from the bench
`timescale 1ns/1ps
module fhl_props(
	input wire         clk,
	input wire         rst,
	input wire         fault_valid,
	input wire         fault_reset,
	input wire [7:0]   fault_action,
	input wire         rd_en,
	input wire         rd_valid,
	input wire         pwr_enable,
	input wire         fault_active,
	input wire [319:0] diag_live,
	input wire [319:0] diag_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	trip_off_a: assert property (fault_valid |=> !pwr_enable && fault_active)
		else $error("output not disabled on fault");
	trip_hold_a: assert property (fault_active && !fault_reset |=> fault_active)
		else $error("trip dropped without clear");
	trip_exit_a: assert property (fault_reset && !fault_valid |=> pwr_enable)
		else $error("output not restored");
	diag_freeze_a: assert property (fault_active && !fault_action[4] |=> $stable(diag_out))
		else $error("diagnostics moved while tripped");
	no_freeze_a: assert property (fault_action[4] |=> diag_out == $past(diag_live))
		else $error("diagnostics frozen though disabled");
	diag_run_a: assert property (!fault_active && !fault_valid |=> diag_out == $past(diag_live))
		else $error("diagnostics not tracking");
	rd_ans_a: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	rd_only_a: assert property (!rd_en |=> !rd_valid)
		else $error("spurious read answer");
endmodule

// ### fhl_slot.v
// Purpose: One log slot: code, sub-code and timestamp held as one word
// Assumes: Shift and clear come from the logger control
// Notes:   Clear wins over shift; both come from one controller cycle
`timescale 1ns/1ps
`include "fhl_defines.vh"
module fhl_slot #(
	parameter W = 56
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         shift,
	input  wire         clear,
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] slot_q;
	assign dout = slot_q;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_q <= {W{1'b0}};
		end else if (clear) begin
			slot_q <= {W{1'b0}};
		end else if (shift) begin
			slot_q <= din;
		end
	end
endmodule

// ### fhl_top.v
// Purpose: Fault history logger with diagnostic freeze and output disable
// Assumes: All inputs synchronous to clk; one fault event per fault_valid pulse
// Notes:   Read data registered, so it appears one cycle after rd_en
`timescale 1ns/1ps
`include "fhl_defines.vh"
module fhl_top #(
	parameter DEPTH  = `FHL_LOG_DEPTH,
	parameter CODE_W = `FHL_CODE_W,
	parameter SUB_W  = `FHL_SUB_W,
	parameter DATE_W = `FHL_DATE_W,
	parameter TIME_W = `FHL_TIME_W,
	parameter DIAG_N = `FHL_DIAG_N,
	parameter DIAG_W = `FHL_DIAG_W
) (
	input  wire                     clk,
	input  wire                     rst,
	input  wire                     fault_valid,
	input  wire [CODE_W-1:0]        fault_code,
	input  wire                     fault_has_sub,
	input  wire [SUB_W-1:0]         fault_sub,
	input  wire [DATE_W-1:0]        cur_date,
	input  wire [TIME_W-1:0]        cur_time,
	input  wire                     fault_reset,
	input  wire [`FHL_ACT_W-1:0]    fault_action,
	input  wire                     clr_wr,
	input  wire                     clr_from_serial,
	input  wire [CODE_W-1:0]        clr_data,
	input  wire                     rd_en,
	input  wire [`FHL_IDX_W-1:0]    rd_idx,
	input  wire [DIAG_N*DIAG_W-1:0] diag_live,
	output reg                      rd_valid,
	output reg  [CODE_W-1:0]        rd_code,
	output reg  [SUB_W-1:0]         rd_sub,
	output reg  [DATE_W-1:0]        rd_date,
	output reg  [TIME_W-1:0]        rd_time,
	output reg                      pwr_enable,
	output reg                      fault_active,
	output reg  [DIAG_N*DIAG_W-1:0] diag_out
);
	localparam ENT_W     = CODE_W + SUB_W + DATE_W + TIME_W;
	localparam DATE_LSB  = TIME_W;
	localparam SUB_LSB   = DATE_LSB + DATE_W;
	localparam CODE_LSB  = SUB_LSB + SUB_W;
	localparam DIAG_BITS = DIAG_N * DIAG_W;

	localparam ST_RUN    = `FHL_ST_RUN;
	localparam ST_TRIP   = `FHL_ST_TRIP;

	reg                        state_q;
	reg                        state_d;

	wire                       clr_src_ok;
	wire                       clr_key_ok;
	wire                       log_clear;

	wire [SUB_W-1:0]           sub_val;
	wire [ENT_W-1:0]           new_entry;
	wire [ENT_W*(DEPTH+1)-1:0] chain;
	wire [ENT_W-1:0]           slot_word [0:DEPTH-1];
	reg  [ENT_W-1:0]           sel_entry;
	wire [CODE_W-1:0]          sel_code;
	wire [SUB_W-1:0]           sel_sub;
	wire [DATE_W-1:0]          sel_date;
	wire [TIME_W-1:0]          sel_time;

	wire                       trip_exit;
	wire                       freeze_off;
	wire                       diag_track;
	wire [DIAG_BITS-1:0]       diag_d;

	integer                    k;

	// Key only honoured on the serial path; local writers cannot wipe the log
	assign clr_src_ok = clr_wr && clr_from_serial;
	assign clr_key_ok = (clr_data == `FHL_CLEAR_KEY);
	assign log_clear  = clr_src_ok && clr_key_ok;

	assign sub_val = fault_has_sub ? fault_sub : {SUB_W{1'b0}};

	// All four fields packed into one word so they can never disagree
	assign new_entry = {fault_code, sub_val, cur_date, cur_time};

	// Chain tap 0 feeds slot zero; tap g+1 is the output of slot g
	assign chain[ENT_W-1:0] = new_entry;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
			fhl_slot #(
				.W(ENT_W)
			) u_slot (
				.clk  (clk),
				.rst  (rst),
				.shift(fault_valid),
				.clear(log_clear),
				.din  (chain[ENT_W*(g+1)-1:ENT_W*g]),
				.dout (chain[ENT_W*(g+2)-1:ENT_W*(g+1)])
			);

			assign slot_word[g] = chain[ENT_W*(g+2)-1:ENT_W*(g+1)];
		end
	endgenerate

	// Indices at or past the depth match no slot and read back as an empty entry
	always @* begin
		sel_entry = {ENT_W{1'b0}};
		for (k = 0; k < DEPTH; k = k + 1) begin
			if (rd_idx == k) begin
				sel_entry = slot_word[k];
			end
		end
	end

	assign sel_code = sel_entry[CODE_LSB +: CODE_W];
	assign sel_sub  = sel_entry[SUB_LSB +: SUB_W];
	assign sel_date = sel_entry[DATE_LSB +: DATE_W];
	assign sel_time = sel_entry[TIME_W-1:0];

	// Answer strobe follows every request by one cycle, whatever the index
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
		end
	end

	// Read sees the log as it stood before a same-cycle shift
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_code <= {CODE_W{1'b0}};
			rd_sub  <= {SUB_W{1'b0}};
			rd_date <= {DATE_W{1'b0}};
			rd_time <= {TIME_W{1'b0}};
		end else if (rd_en) begin
			rd_code <= sel_code;
			rd_sub  <= sel_sub;
			rd_date <= sel_date;
			rd_time <= sel_time;
		end
	end

	// A fault in the same cycle as a reset request keeps the trip
	assign trip_exit = fault_reset && !fault_valid;

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (fault_valid) begin
					state_d = ST_TRIP;
				end
			end
			ST_TRIP: begin
				if (trip_exit) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_active <= 1'b0;
		end else begin
			fault_active <= (state_d == ST_TRIP);
		end
	end

	// Cut from the incoming event, not the state, so no cycle is lost
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pwr_enable <= 1'b0;
		end else begin
			pwr_enable <= (state_d == ST_RUN) && !fault_valid;
		end
	end

	assign freeze_off = fault_action[`FHL_NOFRZ_BIT];

	// Tracking stops on the fault cycle itself, so the snapshot predates the trip
	assign diag_track = ((state_q == ST_RUN) && !fault_valid) || freeze_off;

	// Each channel either follows its live value or recirculates the held one
	genvar d;
	generate
		for (d = 0; d < DIAG_N; d = d + 1) begin : g_diag
			assign diag_d[d*DIAG_W +: DIAG_W] = diag_track ?
				diag_live[d*DIAG_W +: DIAG_W] : diag_out[d*DIAG_W +: DIAG_W];
		end
	endgenerate

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			diag_out <= {DIAG_BITS{1'b0}};
		end else begin
			diag_out <= diag_d;
		end
	end
endmodule
